// ==== src/acrc_pkg.sv ====
package acrc_pkg;
    // Wishbone request bundle seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } acrc_wb_req_t;

    // Register byte offsets
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RATE = 8'h0c;
    localparam logic [7:0] REG_OFFS_BASE = 8'h40;
    localparam logic [7:0] REG_FSC_BASE = 8'h60;

    // Field positions
    localparam int MODE_LSB = 0;
    localparam int CHOP_BIT = 4;
    localparam int CHAN_LSB = 0;
    localparam int GAIN_LSB = 4;
    localparam int RATE_LSB = 8;
    localparam int ST_READY_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_COUNT_LSB = 4;
    localparam int RATE_SETTLE_LSB = 16;

    // Operating modes
    localparam logic [2:0] MODE_CONT = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_IDLE = 3'h2;
    localparam logic [2:0] MODE_PDOWN = 3'h3;
    localparam logic [2:0] MODE_INT_ZERO = 3'h4;
    localparam logic [2:0] MODE_INT_FULL = 3'h5;
    localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
    localparam logic [2:0] MODE_SYS_FULL = 3'h7;

    // Gain codes with special handling
    localparam logic [2:0] GAIN_UNITY = 3'h0;
    localparam logic [2:0] GAIN_128 = 3'h7;

    // Calibration lengths in conversion cycles
    localparam logic [2:0] CAL_LEN_CHOP = 3'h2;
    localparam logic [2:0] CAL_LEN_NOCHOP = 3'h1;
    localparam logic [2:0] CAL_LEN_HIGAIN_CHOP = 3'h4;
    localparam logic [2:0] CAL_LEN_HIGAIN_NOCHOP = 3'h2;

    // Reset values
    localparam logic [2:0] MODE_RST = MODE_CONT;
    localparam logic CHOP_RST = 1'b1;
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [2:0] GAIN_RST = 3'h0;
    localparam logic [3:0] RATE_RST = 4'ha;
    localparam logic [23:0] OFFS_RST = 24'h800000;
    localparam logic [23:0] FSC_RST = 24'h500000;

    // Output rate per rate-select code, in units of 0.01 Hz
    localparam logic [15:0] RATE_CENTIHZ [16] = '{
        16'h0000, 16'hb798, 16'h5e88, 16'h300c, 16'h1838, 16'h1388, 16'h0f3c, 16'h0cf8,
        16'h07a8, 16'h0686, 16'h0686, 16'h04e2, 16'h03e8, 16'h0341, 16'h0271, 16'h01a1};
    // Settling with chop on, in units of 0.5 ms
    localparam logic [9:0] SETTLE_CHOP_HALF_MS [16] = '{
        10'h000, 10'h008, 10'h010, 10'h020, 10'h040, 10'h050, 10'h060, 10'h078,
        10'h0ca, 10'h0f0, 10'h0f0, 10'h140, 10'h190, 10'h1e0, 10'h280, 10'h3c0};
endpackage

// ==== src/acrc_rate_table.sv ====
`timescale 1ns/1ps
module acrc_rate_table (
    input wire logic [3:0] rate_sel_i,
    input wire logic chop_i,
    output logic [15:0] rate_centihz_o,
    output logic [9:0] settle_half_ms_o,
    output logic valid_o
);
    import acrc_pkg::*;

    // Same rate either way; chop off halves the settling time
    always_comb
    begin
        rate_centihz_o = RATE_CENTIHZ[rate_sel_i]; // see RULE_09
        settle_half_ms_o = chop_i ? SETTLE_CHOP_HALF_MS[rate_sel_i]
                                  : {1'b0, SETTLE_CHOP_HALF_MS[rate_sel_i][9:1]}; // see RULE_10
        valid_o = (rate_sel_i != 4'h0); // Code zero has no defined rate
    end
endmodule // acrc_rate_table

// ==== src/acrc_core.sv ====
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Behaviour
// RULE_01: System zero cal ends after 2/1 conversions
// RULE_02: Zero cal result goes to channel offset
// RULE_03: System full cal ends after 2/1 conversions
// RULE_04: Full cal result goes to channel gain
// RULE_05: Ready high during cal, low after
// RULE_06: Enter idle after any calibration
// RULE_07: No internal full cal at gain 128
// RULE_08: Host recalibrates full scale after gain change
// RULE_09: Rate code maps to rate and settling
// RULE_10: Chop off halves settling, same rate
// RULE_11: Internal full cal 2/1, or 4/2 above unity
// RULE_12: Idle resets filter and modulator, clocks run
// RULE_13: Host never writes rate code zero
module acrc_core #(
    parameter int NUM_CH = 8,
    parameter int COEF_W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input acrc_pkg::acrc_wb_req_t wb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic conv_done_i,
    input wire logic [23:0] conv_data_i,
    output logic ready_n_o,
    output logic filter_reset_o,
    output logic modulator_reset_o,
    output logic mod_clk_en_o,
    output logic cal_active_o
);
    import acrc_pkg::*;

    typedef enum logic {ST_RUN, ST_CAL} acrc_state_t;

    // Coefficient storage is indexed by the three select bits
    if (NUM_CH != 8 || COEF_W != 24)
    begin : g_check
        $error("acrc_core serves only 8 channels of 24-bit coefficients");
    end

    acrc_state_t state_reg, state_next;
    logic [2:0] mode_reg, mode_next;
    logic chop_reg, chop_next;
    logic [2:0] chan_reg, chan_next;
    logic [2:0] gain_reg, gain_next;
    logic [3:0] rate_reg, rate_next;
    logic [2:0] cal_cnt_reg, cal_cnt_next;
    logic [2:0] cal_len_reg, cal_len_next;
    logic [2:0] cal_kind_reg, cal_kind_next;
    logic [2:0] cal_chan_reg, cal_chan_next;
    logic refused_reg, refused_next;
    logic ready_n_reg, ready_n_next;
    logic [23:0] offs_reg [8];
    logic [23:0] offs_next [8];
    logic [23:0] fsc_reg [8];
    logic [23:0] fsc_next [8];
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [15:0] rate_centihz;
    logic [9:0] settle_half_ms;
    logic rate_valid;
    logic wr_en;
    logic [2:0] wr_mode;
    logic [31:0] mode_w;
    logic cal_req;
    logic cal_refuse;
    logic cal_start;
    logic cal_finish;
    logic cal_is_zero;

    acrc_rate_table u_rate (
        .rate_sel_i(rate_reg),
        .chop_i(chop_reg),
        .rate_centihz_o(rate_centihz),
        .settle_half_ms_o(settle_half_ms),
        .valid_o(rate_valid)
    );

    // Merge write data into a register under the byte enables
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Write lands on the edge where the master samples ack
    assign wr_en = wb_i.cyc && wb_i.stb && wb_i.we && ack_reg;
    assign mode_w = lane_merge({29'h0, mode_reg}, wb_i.dat, wb_i.sel);
    assign wr_mode = mode_w[2:0];
    assign cal_req = wr_en && (wb_i.adr == REG_MODE) && wr_mode[2] && (state_reg == ST_RUN);
    assign cal_refuse = cal_req && (wr_mode == MODE_INT_FULL) && (gain_reg == GAIN_128); // see RULE_07
    assign cal_start = cal_req && !cal_refuse;
    assign cal_is_zero = (cal_kind_reg == MODE_INT_ZERO) || (cal_kind_reg == MODE_SYS_ZERO);
    assign cal_finish = (state_reg == ST_CAL) && conv_done_i
        && (3'(cal_cnt_reg + 3'h1) == cal_len_reg); // see RULE_01 RULE_03 RULE_11

    // Mode, configuration and calibration sequencing
    always_comb
    begin
        logic [31:0] cfg_w;
        logic [31:0] offs_w;
        logic [31:0] fsc_w;
        cfg_w = lane_merge({20'h0, rate_reg, 1'b0, gain_reg, 1'b0, chan_reg}, wb_i.dat, wb_i.sel);
        offs_w = lane_merge({8'h0, offs_reg[wb_i.adr[4:2]]}, wb_i.dat, wb_i.sel);
        fsc_w = lane_merge({8'h0, fsc_reg[wb_i.adr[4:2]]}, wb_i.dat, wb_i.sel);
        state_next = state_reg;
        mode_next = mode_reg;
        chop_next = chop_reg;
        chan_next = chan_reg;
        gain_next = gain_reg;
        rate_next = rate_reg;
        cal_cnt_next = cal_cnt_reg;
        cal_len_next = cal_len_reg;
        cal_kind_next = cal_kind_reg;
        cal_chan_next = cal_chan_reg;
        refused_next = refused_reg;
        ready_n_next = ready_n_reg;
        offs_next = offs_reg;
        fsc_next = fsc_reg;
        if (wr_en && wb_i.adr == REG_CONFIG)
        begin
            chan_next = cfg_w[CHAN_LSB +: 3];
            gain_next = cfg_w[GAIN_LSB +: 3];
            rate_next = cfg_w[RATE_LSB +: 4];
        end
        // Status refusal flag is write-one-to-clear; a new refusal wins
        if (wr_en && wb_i.adr == REG_STATUS && wb_i.sel[0] && wb_i.dat[ST_REFUSED_BIT])
        begin
            refused_next = 1'b0;
        end
        if (cal_refuse)
        begin
            refused_next = 1'b1; // see RULE_07
        end
        // Software may also load coefficients directly
        if (wr_en && wb_i.adr[7:5] == REG_OFFS_BASE[7:5])
        begin
            offs_next[wb_i.adr[4:2]] = offs_w[23:0];
        end
        if (wr_en && wb_i.adr[7:5] == REG_FSC_BASE[7:5])
        begin
            fsc_next[wb_i.adr[4:2]] = fsc_w[23:0];
        end
        unique case (state_reg)
            ST_RUN:
            begin
                if (wr_en && wb_i.adr == REG_MODE && !cal_refuse)
                begin
                    mode_next = wr_mode;
                    if (wb_i.sel[0])
                    begin
                        chop_next = wb_i.dat[CHOP_BIT];
                    end
                    ready_n_next = 1'b1;
                end
                if (cal_start)
                begin
                    state_next = ST_CAL;
                    cal_cnt_next = 3'h0;
                    cal_kind_next = wr_mode;
                    cal_chan_next = chan_reg; // Channel frozen for the whole cal
                    if (wr_mode == MODE_INT_FULL && gain_reg != GAIN_UNITY)
                    begin
                        cal_len_next = chop_next ? CAL_LEN_HIGAIN_CHOP
                                                 : CAL_LEN_HIGAIN_NOCHOP; // see RULE_11
                    end
                    else
                    begin
                        cal_len_next = chop_next ? CAL_LEN_CHOP
                                                 : CAL_LEN_NOCHOP; // see RULE_01 RULE_03
                    end
                end
                else if (conv_done_i && (mode_reg == MODE_CONT || mode_reg == MODE_SINGLE))
                begin
                    ready_n_next = 1'b0;
                    if (mode_reg == MODE_SINGLE)
                    begin
                        mode_next = MODE_IDLE;
                    end
                end
            end
            ST_CAL:
            begin
                // Mode writes are ignored until the calibration ends
                if (conv_done_i)
                begin
                    cal_cnt_next = 3'(cal_cnt_reg + 3'h1);
                end
                if (cal_finish)
                begin
                    if (cal_is_zero)
                    begin
                        offs_next[cal_chan_reg] = conv_data_i; // see RULE_02
                    end
                    else
                    begin
                        fsc_next[cal_chan_reg] = conv_data_i; // see RULE_04
                    end
                    state_next = ST_RUN;
                    mode_next = MODE_IDLE; // see RULE_06
                    ready_n_next = 1'b0; // see RULE_05
                end
            end
        endcase
    end

    // Register read mux and single-wait-state ack
    always_comb
    begin
        ack_next = wb_i.cyc && wb_i.stb && !ack_reg;
        dat_next = 32'h0; // Unmapped and reserved read as zero
        if (wb_i.adr == REG_MODE)
        begin
            dat_next = {27'h0, chop_reg, 1'b0, mode_reg};
        end
        else if (wb_i.adr == REG_CONFIG)
        begin
            dat_next = {20'h0, rate_reg, 1'b0, gain_reg, 1'b0, chan_reg};
        end
        else if (wb_i.adr == REG_STATUS)
        begin
            dat_next = {25'h0, cal_cnt_reg, 1'b0, state_reg == ST_CAL, refused_reg, ready_n_reg};
        end
        else if (wb_i.adr == REG_RATE)
        begin
            dat_next = {5'h0, !rate_valid, settle_half_ms, rate_centihz};
        end
        else if (wb_i.adr[7:5] == REG_OFFS_BASE[7:5])
        begin
            dat_next = {8'h0, offs_reg[wb_i.adr[4:2]]};
        end
        else if (wb_i.adr[7:5] == REG_FSC_BASE[7:5])
        begin
            dat_next = {8'h0, fsc_reg[wb_i.adr[4:2]]};
        end
    end

    // State registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_RUN;
            mode_reg <= MODE_RST;
            chop_reg <= CHOP_RST;
            chan_reg <= CHAN_RST;
            gain_reg <= GAIN_RST;
            rate_reg <= RATE_RST;
            cal_cnt_reg <= 3'h0;
            cal_len_reg <= CAL_LEN_NOCHOP;
            cal_kind_reg <= MODE_INT_ZERO;
            cal_chan_reg <= CHAN_RST;
            refused_reg <= 1'b0;
            ready_n_reg <= 1'b1;
            offs_reg <= '{default: OFFS_RST};
            fsc_reg <= '{default: FSC_RST};
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end
        else
        begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            chop_reg <= chop_next;
            chan_reg <= chan_next;
            gain_reg <= gain_next;
            rate_reg <= rate_next;
            cal_cnt_reg <= cal_cnt_next;
            cal_len_reg <= cal_len_next;
            cal_kind_reg <= cal_kind_next;
            cal_chan_reg <= cal_chan_next;
            refused_reg <= refused_next;
            ready_n_reg <= ready_n_next;
            offs_reg <= offs_next;
            fsc_reg <= fsc_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // Idle and power-down hold filter and modulator in reset
    assign filter_reset_o = (mode_reg == MODE_IDLE) || (mode_reg == MODE_PDOWN); // see RULE_12
    assign modulator_reset_o = filter_reset_o;
    assign mod_clk_en_o = (mode_reg != MODE_PDOWN); // see RULE_12
    assign cal_active_o = (state_reg == ST_CAL);
    assign ready_n_o = ready_n_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_CAL_READY: assert property (cal_start |=> ready_n_o && cal_active_o)
        else $error("ready not raised at calibration start"); // see RULE_05
    AST_CAL_END: assert property (cal_finish |=> !ready_n_o && mode_reg == MODE_IDLE && !cal_active_o)
        else $error("calibration end did not go idle with ready low"); // see RULE_06
    AST_ZERO_LEN: assert property ((cal_start && wr_mode[1:0] == 2'b10)
        |=> cal_len_reg == ($past(chop_next) ? 3'h2 : 3'h1))
        else $error("system zero cal length wrong"); // see RULE_01
    AST_SYSFS_LEN: assert property ((cal_start && wr_mode == MODE_SYS_FULL)
        |=> cal_len_reg == ($past(chop_next) ? 3'h2 : 3'h1))
        else $error("system full cal length wrong"); // see RULE_03
    AST_INTFS_LEN: assert property ((cal_start && wr_mode == MODE_INT_FULL && gain_reg != 3'h0)
        |=> cal_len_reg == ($past(chop_next) ? 3'h4 : 3'h2))
        else $error("internal full cal length wrong"); // see RULE_11
    AST_GAIN128: assert property ((cal_req && wr_mode == MODE_INT_FULL && gain_reg == 3'h7)
        |=> !cal_active_o && refused_reg && $stable(mode_reg))
        else $error("internal full cal ran at gain 128"); // see RULE_07
    AST_OFFS_STORE: assert property ((cal_finish && cal_is_zero)
        |=> offs_reg[$past(cal_chan_reg)] == $past(conv_data_i))
        else $error("offset coefficient not stored"); // see RULE_02
    AST_FSC_STORE: assert property ((cal_finish && !cal_is_zero)
        |=> fsc_reg[$past(cal_chan_reg)] == $past(conv_data_i))
        else $error("full-scale coefficient not stored"); // see RULE_04
    AST_IDLE_CLOCKS: assert property (cal_finish |=> filter_reset_o && mod_clk_en_o)
        else $error("idle after cal not holding reset with clocks"); // see RULE_12
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_NOCHOP_HALF: assert property ( // see RULE_10
        (!chop_reg && rate_reg == 4'hf) |-> settle_half_ms == 10'h1e0)
        else $error("slowest code not halved with chop off");
    AST_TOP_RATE: assert property ( // see RULE_09
        (rate_reg == 4'h1) |-> rate_centihz == 16'hb798)
        else $error("fastest code gives wrong rate");
endmodule // acrc_core

// ==== test/acrc_conv_model.sv ====
`timescale 1ns/1ps
// Converter stand-in: one end-of-conversion pulse per request, gap_i + 1 cycles after the request is sampled
module acrc_conv_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [7:0] gap_i,
    output logic conv_done_o,
    output logic [23:0] conv_data_o
);
    logic busy_reg;
    logic [7:0] cnt_reg;
    logic [23:0] lfsr_reg;
    // Data toggles outside the pulse so a stale result never looks valid
    always_ff @(posedge clk_i)
    begin
        conv_done_o <= 1'b0;
        conv_data_o <= ~conv_data_o;
        if (rst_i)
        begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            lfsr_reg <= 24'h5a1c3e;
            conv_data_o <= 24'h000000;
        end
        else if (fire_i)
        begin
            busy_reg <= 1'b1;
            cnt_reg <= gap_i;
        end
        else if (busy_reg && cnt_reg == 8'h00)
        begin
            busy_reg <= 1'b0;
            conv_done_o <= 1'b1;
            conv_data_o <= lfsr_reg;
            lfsr_reg <= {lfsr_reg[22:0], lfsr_reg[23] ^ lfsr_reg[22] ^ lfsr_reg[16]};
        end
        else if (busy_reg)
            cnt_reg <= cnt_reg - 8'h01;
    end
endmodule // acrc_conv_model

// ==== test/adc_calibration_and_rate_control_bench.sv ====
`timescale 1ns/1ps
`define CHK(g, w) begin total_checks++; if ((g) !== (w)) begin failures++; \
    $display("wrong value at %0t: got %h want %h", $time, (g), (w)); end end
module adc_calibration_and_rate_control_bench;
    import acrc_pkg::*;
    logic clk_i, rst_i, fire, wb_ack_o, conv_done_i, ready_n_o;
    logic filter_reset_o, modulator_reset_o, mod_clk_en_o, cal_active_o;
    logic [7:0] gap;
    logic [23:0] conv_data_i, last;
    logic [31:0] wb_dat_o, e, m;
    logic [31:0] q_exp[$], q_msk[$];
    acrc_wb_req_t wb_i;
    int failures = 0, total_checks = 0;
    integer seed = 32'h6e8beafa;
    int rate_cz[15] = '{47000, 24200, 12300, 6200, 5000, 3900, 3320, 1960, 1670, 1670,
        1250, 1000, 833, 625, 417};
    int settle_ms[15] = '{4, 8, 16, 32, 40, 48, 60, 101, 120, 120, 160, 200, 240, 320, 480};

    acrc_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
        .ready_n_o(ready_n_o), .filter_reset_o(filter_reset_o),
        .modulator_reset_o(modulator_reset_o), .mod_clk_en_o(mod_clk_en_o),
        .cal_active_o(cal_active_o));
    acrc_conv_model conv_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .gap_i(gap),
        .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));

    // Free-running 10 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One classic cycle; entered right after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (i == 20)
        begin
            failures++;
            test_done();
        end
        wb_i <= '0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
        q_exp.push_back(x);
        q_msk.push_back(k);
        bus(a, 1'b0, 32'h00000000);
    endtask

    // Ask the converter for one result, slow or prompt; returns at the pulse edge
    task automatic conv();
        int i;
        gap <= 8'($random(seed)) & 8'h1f;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        for (i = 0; i < 300; i++)
        begin
            @(posedge clk_i);
            if (conv_done_i === 1'b1)
                break;
        end
        last = conv_data_i;
        if (i == 300)
        begin
            failures++;
            test_done();
        end
    endtask

    // Run one calibration of n conversions on a random channel
    task automatic cal(input logic [2:0] md, input logic [2:0] gn, input logic cp, input int n);
        logic [2:0] ch;
        logic [7:0] base;
        ch = 3'($random(seed));
        base = (md == MODE_SYS_FULL || md == MODE_INT_FULL) ? REG_FSC_BASE : REG_OFFS_BASE;
        wr(REG_CONFIG, {20'h0, 4'ha, 1'b0, gn, 1'b0, ch});
        wr(REG_MODE, {27'h0, cp, 1'b0, md});
        @(negedge clk_i);
        `CHK(ready_n_o, 1'b1)
        `CHK(cal_active_o, 1'b1)
        for (int i = 1; i <= n; i++)
        begin
            @(posedge clk_i);
            conv();
            @(negedge clk_i);
            `CHK(ready_n_o, (i < n))
            `CHK(cal_active_o, (i < n))
            if (i == 1 && n > 1)
            begin
                @(posedge clk_i);
                wr(REG_MODE, 32'h00000010);
            end
        end
        `CHK(filter_reset_o, 1'b1)
        `CHK(modulator_reset_o, 1'b1)
        `CHK(mod_clk_en_o, 1'b1)
        @(posedge clk_i);
        rd(REG_MODE, {27'h0, cp, 1'b0, MODE_IDLE}, 32'hffffffff);
        rd(base + {2'b0, ch, 2'b0}, {8'h00, last}, 32'hffffffff);
    endtask

    // Read checker: oldest note against each acknowledged read
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_i.we === 1'b0)
        begin
            if (q_exp.size() == 0)
                `CHK(1'b1, 1'b0)
            else
            begin
                e = q_exp.pop_front();
                m = q_msk.pop_front();
                `CHK(wb_dat_o & m, e)
            end
        end
    end

    // Main sequence
    initial
    begin
        logic [2:0] md, gn;
        rst_i = 1'b1;
        wb_i = '0;
        fire = 1'b0;
        gap = 8'h00;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK({ready_n_o, filter_reset_o, mod_clk_en_o, cal_active_o}, 4'b1010)
        @(posedge clk_i);
        rd(REG_MODE, 32'h00000010, 32'hffffffff);
        rd(REG_CONFIG, 32'h00000a00, 32'hffffffff);
        for (int c = 0; c < 8; c++)
        begin
            rd(REG_OFFS_BASE + 8'(c * 4), 32'h00800000, 32'hffffffff);
            rd(REG_FSC_BASE + 8'(c * 4), 32'h00500000, 32'hffffffff);
        end
        wr(8'h20, 32'h12345678);
        rd(8'h20, 32'h00000000, 32'hffffffff);
        $display("test reset and map done");
        // Code zero is never written, it has no defined rate
        for (int c = 1; c < 16; c++)
        begin
            for (int cp = 0; cp < 2; cp++)
            begin
                wr(REG_MODE, {27'h0, cp[0], 1'b0, MODE_IDLE});
                wr(REG_CONFIG, {20'h0, c[3:0], 8'h00});
                rd(REG_RATE, {6'h0, 10'(cp ? settle_ms[c - 1] * 2 : settle_ms[c - 1]),
                    16'(rate_cz[c - 1])}, 32'hffffffff);
            end
        end
        $display("test rates done");
        wr(REG_MODE, 32'h00000013);
        @(negedge clk_i);
        `CHK(mod_clk_en_o, 1'b0)
        `CHK(filter_reset_o, 1'b1)
        @(posedge clk_i);
        cal(MODE_INT_ZERO, GAIN_UNITY, 1'b1, 2);
        for (int k = 0; k < 8; k++)
        begin
            md = (k < 2) ? MODE_SYS_ZERO : (k < 4) ? MODE_SYS_FULL : MODE_INT_FULL;
            gn = (k < 6) ? GAIN_UNITY : 3'(($random(seed) & 3) + 1);
            cal(md, gn, ~k[0], (md == MODE_INT_FULL && gn != 3'h0) ? (k[0] ? 2 : 4)
                : (k[0] ? 1 : 2));
        end
        $display("test calibrations done");
        wr(REG_MODE, 32'h00000012);
        wr(REG_CONFIG, 32'h00000a70);
        wr(REG_MODE, 32'h00000015);
        rd(REG_MODE, 32'h00000012, 32'hffffffff);
        rd(REG_STATUS, 32'h00000002, 32'h00000002);
        wr(REG_STATUS, 32'h00000002);
        rd(REG_STATUS, 32'h00000000, 32'h00000002);
        cal(MODE_SYS_FULL, GAIN_128, 1'b1, 2);
        $display("test top gain done");
        repeat (2) @(posedge clk_i);
        test_done();
    end
endmodule // adc_calibration_and_rate_control_bench
